/* logic/flash_front_pkg.sv */
// constants and types shared by the serial flash front end
// assumes a single 100 MHz system clock and a sampled link clock
package flash_front_pkg;
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          BYTE_BITS       = 8;
  localparam int          PAGE_BYTES      = 256;
  localparam int          PAGES_PER_SECT  = 256;
  localparam int          SECTORS         = 32;
  localparam int          PP_MIN_BYTES    = 1;
  localparam int          PP_MAX_BYTES    = 256;
  localparam int          ADDR_BITS       = 21;
  localparam int          PAGE_OFS_LSB    = 0;
  localparam int          PAGE_IDX_LSB    = 8;
  localparam int          SECT_IDX_LSB    = 16;
  localparam int          BUF_DEPTH       = 2;
  localparam logic [7:0]  OUT_RESET_BYTE  = 8'hff;
  localparam logic [2:0]  PROTECT_RESET   = 3'h0;

  typedef enum logic [2:0] {
    ST_UNARMED = 3'b001,
    ST_STANDBY = 3'b010,
    ST_ACTIVE  = 3'b100
  } power_state_type;
endpackage : flash_front_pkg

/* logic/byte_stream_if.sv */
// valid/ready byte stream between the front end's own modules
// assumes both ends run on CLK_SYS
interface byte_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : byte_stream_if

/* logic/byte_buffer.sv */
// small valid/ready buffer on a byte stream
// assumes CLK_SYS domain on both sides
module byte_buffer
  import flash_front_pkg::*;
#(
  parameter int WIDTH = BYTE_BITS,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic  clk,     // system clock
  input  wire logic  rst,     // sync reset
  input  wire logic  flush,   // drop contents
  byte_stream_if.sink   in_s, // filling side
  byte_stream_if.source out_s // draining side
);
  initial if (DEPTH != 2 || WIDTH != 8) $error("byte_buffer supports 2 x 8 only");

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  logic             push;
  logic             pop;

  assign in_s.ready  = (cnt_r != 2'h2);
  assign out_s.valid = (cnt_r != 2'h0);
  assign out_s.data  = mem_r[rp_r];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : byte_buffer

/* logic/link_sampler.sv */
// two-flop synchronisers for the link pins and edge detection of the link clock
// assumes all inputs are asynchronous to CLK_SYS
module link_sampler (
  input  wire logic clk,        // system clock
  input  wire logic rst,        // sync reset
  input  wire logic sck_pin,    // link clock pin
  input  wire logic sel_n_pin,  // select pin
  input  wire logic din_pin,    // data in pin
  input  wire logic pause_n_pin,// pause pin
  input  wire logic wprot_n_pin,// write protect pin
  output logic      sck_rise,   // link clock rising edge pulse
  output logic      sck_fall,   // link clock falling edge pulse
  output logic      sel_n,      // synced select
  output logic      sel_fall,   // select falling edge pulse
  output logic      din,        // synced data in
  output logic      pause_n,    // synced pause
  output logic      wprot_n     // synced write protect
);
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       sck_d_r;
  logic       sel_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r  <= 5'h1a;
      sync_r  <= 5'h1a;
      sck_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end else begin
      meta_r  <= {wprot_n_pin, pause_n_pin, din_pin, sel_n_pin, sck_pin};
      sync_r  <= meta_r;
      sck_d_r <= sync_r[0];
      sel_d_r <= sync_r[1];
    end
  end

  assign sck_rise = sync_r[0] && !sck_d_r;
  assign sck_fall = !sync_r[0] && sck_d_r;
  assign sel_n    = sync_r[1];
  assign sel_fall = !sync_r[1] && sel_d_r;
  assign din      = sync_r[2];
  assign pause_n  = sync_r[3];
  assign wprot_n  = sync_r[4];
endmodule : link_sampler

/* logic/flash_spi_front.sv */
// serial flash link front end: select, power state, pause, shifting, geometry
// assumes link pins are asynchronous, sampled by CLK_SYS; the core behind
// the byte ports decodes instructions and runs program and erase cycles
//
// Function
// - the output bit changes after each falling edge of the link clock.
// - the input bit is sampled on each rising edge of the link clock.
// - while select is high the device is deselected and the output floats.
// - deselected with no internal cycle running, the device sits in standby once armed by a select falling edge.
// - select low makes the device selected and active.
// - no instruction is taken after power-up until a select falling edge.
// - pause suspends the transfer while selected, and it resumes afterwards.
// - while paused the output floats and data in and link clock are ignored.
// - write protect can lock the three protect size bits against change.
// - one page program takes between 1 and 256 data bytes.
// - the array has 32 sectors of 256 pages each.
// - each page holds 256 bytes at consecutive addresses.
// - a sector or the whole array can be erased, each by its own instruction.
module flash_spi_front
  import flash_front_pkg::*;
(
  input  wire logic        CLK_SYS,          // system clock, 100 MHz
  input  wire logic        RST,              // sync reset, active high
  input  wire logic        SCK,              // link clock pin
  input  wire logic        SEL_N,            // select pin, active low
  input  wire logic        DIN,              // serial data in pin
  input  wire logic        PAUSE_N,          // pause pin, active low
  input  wire logic        WPROT_N,          // write protect pin, active low
  output logic             DOUT_O,           // serial data out value
  output logic             DOUT_OE_N,        // data out enable, low drives
  output logic [7:0]       RX_DATA,          // received byte
  output logic             RX_VALID,         // received byte valid
  input  wire logic        RX_READY,         // core takes received byte
  output logic             RX_FIRST,         // received byte is first of frame
  input  wire logic [7:0]  TX_DATA,          // next byte to send
  input  wire logic        TX_LOAD,          // load TX_DATA for next byte
  output logic             TX_NEED,          // pulse: a byte boundary passed
  output logic             FRAME_END,        // pulse: select rose, frame ended
  output logic             FRAME_WHOLE,      // last frame had whole bytes
  input  wire logic        BUSY,             // core internal cycle running
  output logic             STANDBY,          // standby power state
  output logic             ACTIVE,           // active power state
  input  wire logic [2:0]  PROT_REQ,         // requested protect size bits
  input  wire logic        PROT_WR,          // core writes protect size bits
  input  wire logic        PROT_LOCK_EN,     // core lock bit enables pin lock
  output logic [2:0]       PROT_SIZE,        // protect_size_bit2..0
  input  wire logic [ADDR_BITS-1:0] ADDR_IN, // byte address to split
  output logic [4:0]       SECTOR_IDX,       // sector of ADDR_IN
  output logic [7:0]       PAGE_IDX,         // page within sector
  output logic [7:0]       PAGE_OFS,         // byte within page
  output logic [ADDR_BITS-1:0] PAGE_NEXT     // next address, wraps in page
);
  localparam int ARRAY_BYTES = SECTORS * PAGES_PER_SECT * PAGE_BYTES;
  initial if (ARRAY_BYTES != (1 << ADDR_BITS)) $error("geometry mismatch");
  initial if (PP_MAX_BYTES != PAGE_BYTES || PP_MIN_BYTES < 1) $error("page size");
  // field positions must follow the page and sector sizes
  initial if ((1 << PAGE_IDX_LSB) != PAGE_BYTES) $error("page field");
  initial if ((1 << (SECT_IDX_LSB - PAGE_IDX_LSB)) != PAGES_PER_SECT) $error("sector field");
  // the shifters and the side tags serve 8-bit bytes and a 2-entry buffer only
  initial if (BYTE_BITS != 8 || BUF_DEPTH != 2) $error("byte path size");

  logic sck_rise;
  logic sck_fall;
  logic sel_n;
  logic sel_fall;
  logic din;
  logic pause_n;
  logic wprot_n;

  link_sampler u_samp (
    .clk         (CLK_SYS),
    .rst         (RST),
    .sck_pin     (SCK),
    .sel_n_pin   (SEL_N),
    .din_pin     (DIN),
    .pause_n_pin (PAUSE_N),
    .wprot_n_pin (WPROT_N),
    .sck_rise    (sck_rise),
    .sck_fall    (sck_fall),
    .sel_n       (sel_n),
    .sel_fall    (sel_fall),
    .din         (din),
    .pause_n     (pause_n),
    .wprot_n     (wprot_n)
  );

  // address split; page offset wraps inside one page
  function automatic logic [ADDR_BITS-1:0] page_inc(input logic [ADDR_BITS-1:0] a);
    page_inc = {a[ADDR_BITS-1:PAGE_IDX_LSB], a[PAGE_IDX_LSB-1:0] + 8'h01};
  endfunction : page_inc

  power_state_type pstate_r;
  power_state_type pstate_nxt;
  logic            selected;
  logic            paused;
  logic            link_on;

  assign selected = !sel_n && (pstate_r != ST_UNARMED);
  assign paused   = selected && !pause_n;
  assign link_on  = selected && pause_n;

  // link clock edges that count; pause and deselect mask both
  logic shift_in;
  logic shift_out;

  assign shift_in  = link_on && sck_rise;
  assign shift_out = link_on && sck_fall;

  always_comb begin
    pstate_nxt = pstate_r;
    case (pstate_r)
      ST_UNARMED: begin
        if (sel_fall) begin
          pstate_nxt = ST_ACTIVE;
        end
      end
      ST_STANDBY: begin
        if (!sel_n) begin
          pstate_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sel_n && !BUSY) begin
          pstate_nxt = ST_STANDBY;
        end
      end
      default: begin
        pstate_nxt = ST_UNARMED;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pstate_r <= ST_UNARMED;
      STANDBY  <= 1'b0;
      ACTIVE   <= 1'b0;
    end else begin
      pstate_r <= pstate_nxt;
      STANDBY  <= (pstate_nxt == ST_STANDBY);
      ACTIVE   <= (pstate_nxt == ST_ACTIVE);
    end
  end

  // receive shifter
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic       first_r;
  logic       byte_done;

  assign byte_done = shift_in && (bit_cnt_r == 3'h7);

  always_ff @(posedge CLK_SYS) begin
    if (RST || sel_n) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r   <= 8'h00;
    end else if (shift_in) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r   <= {rx_sh_r[6:0], din};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || sel_n) begin
      first_r <= 1'b1;
    end else if (byte_done) begin
      first_r <= 1'b0;
    end
  end

  // byte buffer towards the core; first-of-frame flag rides in a side reg
  byte_stream_if rx_in ();
  byte_stream_if rx_out ();
  logic [1:0] first_tag_r;
  logic       first_wp_r;
  logic       first_rp_r;

  assign rx_in.valid  = byte_done;
  assign rx_in.data   = {rx_sh_r[6:0], din};
  assign rx_out.ready = RX_READY && RX_VALID;

  byte_buffer #(.WIDTH(BYTE_BITS), .DEPTH(BUF_DEPTH)) u_rxbuf (
    .clk   (CLK_SYS),
    .rst   (RST),
    .flush (1'b0),
    .in_s  (rx_in.sink),
    .out_s (rx_out.source)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      first_tag_r <= 2'h0;
      first_wp_r  <= 1'b0;
      first_rp_r  <= 1'b0;
    end else begin
      if (rx_in.valid && rx_in.ready) begin
        first_tag_r[first_wp_r] <= first_r;
        first_wp_r              <= ~first_wp_r;
      end
      if (rx_out.valid && rx_out.ready) begin
        first_rp_r <= ~first_rp_r;
      end
    end
  end

  // registered output stage of the stream; a byte is dropped only if the
  // core stalls for two whole bytes
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RX_VALID <= 1'b0;
      RX_DATA  <= 8'h00;
      RX_FIRST <= 1'b0;
    end else if (!RX_VALID || RX_READY) begin
      RX_VALID <= rx_out.valid && !(RX_VALID && RX_READY);
      RX_DATA  <= rx_out.data;
      RX_FIRST <= first_tag_r[first_rp_r];
    end
  end

  // transmit shifter: next bit presented after each falling edge
  logic [7:0] tx_sh_r;
  logic [7:0] tx_hold_r;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_hold_r <= OUT_RESET_BYTE;
    end else if (TX_LOAD) begin
      tx_hold_r <= TX_DATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || sel_n) begin
      tx_sh_r <= OUT_RESET_BYTE;
      DOUT_O  <= 1'b1;
    end else if (shift_out) begin
      if (bit_cnt_r == 3'h0) begin
        tx_sh_r <= {tx_hold_r[6:0], 1'b1};
        DOUT_O  <= tx_hold_r[7];
      end else begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b1};
        DOUT_O  <= tx_sh_r[7];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DOUT_OE_N <= 1'b1;
    end else begin
      DOUT_OE_N <= !(selected && !paused);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      TX_NEED     <= 1'b0;
      FRAME_END   <= 1'b0;
      FRAME_WHOLE <= 1'b0;
    end else begin
      TX_NEED   <= byte_done;
      FRAME_END <= frame_closing;
      if (!sel_n) begin
        FRAME_WHOLE <= (bit_cnt_r == 3'h0);
      end
    end
  end

  // a frame closes once, in the cycle select is seen high after a whole byte
  logic frame_closing;
  assign frame_closing = sel_n && (pstate_r == ST_ACTIVE) && !first_r;

  // protect size bits, frozen when the pin lock is armed and the pin is low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PROT_SIZE <= PROTECT_RESET;
    end else if (PROT_WR && !(PROT_LOCK_EN && !wprot_n)) begin
      PROT_SIZE <= PROT_REQ;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      SECTOR_IDX <= 5'h00;
      PAGE_IDX   <= 8'h00;
      PAGE_OFS   <= 8'h00;
      PAGE_NEXT  <= '0;
    end else begin
      SECTOR_IDX <= ADDR_IN[ADDR_BITS-1:SECT_IDX_LSB];
      PAGE_IDX   <= ADDR_IN[SECT_IDX_LSB-1:PAGE_IDX_LSB];
      PAGE_OFS   <= ADDR_IN[PAGE_IDX_LSB-1:PAGE_OFS_LSB];
      PAGE_NEXT  <= page_inc(ADDR_IN);
    end
  end
endmodule : flash_spi_front

/* tb/flash_front_monitor.sv */
// concurrent checks on the link front end ports
// assumes a bind to flash_spi_front, one clock domain and a sync reset
module flash_front_monitor (
  input wire logic       CLK_SYS,      // clock
  input wire logic       RST,          // reset
  input wire logic       SEL_N,        // select
  input wire logic       PAUSE_N,      // pause
  input wire logic       WPROT_N,      // write protect
  input wire logic       DOUT_OE_N,    // out enable
  input wire logic [7:0] RX_DATA,      // rx byte
  input wire logic       RX_VALID,     // rx valid
  input wire logic       RX_READY,     // rx ready
  input wire logic       BUSY,         // core busy
  input wire logic       ACTIVE,       // active state
  input wire logic [2:0] PROT_REQ,     // protect request
  input wire logic       PROT_WR,      // protect write
  input wire logic       PROT_LOCK_EN, // lock enable
  input wire logic [2:0] PROT_SIZE     // protect bits
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic armed_r;
  // set once any select fall is seen; the device may arm later, never earlier
  always_ff @(posedge CLK_SYS) armed_r <= RST ? 1'b0 : (armed_r | $fell(SEL_N));
  property p_desel_float; SEL_N [*6] |-> DOUT_OE_N; endproperty
  a_desel_float: assert property (p_desel_float) else $error("out drives deselected");
  property p_pause_float; (!PAUSE_N) [*6] |-> DOUT_OE_N; endproperty
  a_pause_float: assert property (p_pause_float) else $error("out drives paused");
  property p_sel_active; $fell(SEL_N) ##1 (!SEL_N) [*6] |=> ACTIVE; endproperty
  a_sel_active: assert property (p_sel_active) else $error("not active when selected");
  property p_standby; (SEL_N && !BUSY) [*8] |-> !ACTIVE; endproperty
  a_standby: assert property (p_standby) else $error("active while idle");
  property p_unarmed; !armed_r |-> DOUT_OE_N && !RX_VALID; endproperty
  a_unarmed: assert property (p_unarmed) else $error("traffic before select fall");
  property p_rx_hold; RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte lost");
  property p_lock; (!WPROT_N) [*4] ##0 (PROT_WR && PROT_LOCK_EN) |=> $stable(PROT_SIZE); endproperty
  a_lock: assert property (p_lock) else $error("locked protect bits changed");
  property p_prot_wr; PROT_WR && !PROT_LOCK_EN |=> PROT_SIZE == $past(PROT_REQ); endproperty
  a_prot_wr: assert property (p_prot_wr) else $error("protect bits not written");
  c_stall: cover property (RX_VALID && !RX_READY);
  c_pause: cover property (!PAUSE_N && !SEL_N);
  c_busy: cover property (ACTIVE && BUSY && SEL_N);
endmodule : flash_front_monitor
bind flash_spi_front flash_front_monitor mon (.CLK_SYS(CLK_SYS), .RST(RST), .SEL_N(SEL_N),
  .PAUSE_N(PAUSE_N), .WPROT_N(WPROT_N), .DOUT_OE_N(DOUT_OE_N), .RX_DATA(RX_DATA),
  .RX_VALID(RX_VALID), .RX_READY(RX_READY), .BUSY(BUSY), .ACTIVE(ACTIVE), .PROT_REQ(PROT_REQ),
  .PROT_WR(PROT_WR), .PROT_LOCK_EN(PROT_LOCK_EN), .PROT_SIZE(PROT_SIZE));

/* tb/spi_master_model.sv */
// master model of the serial link: select, link clock, data and pause
// assumes an 80 ns link clock and mode 0 or 3 chosen per frame
module spi_master_model (
  output logic      sck,       // link clock
  output logic      sel_n,     // select
  output logic      din,       // data to device
  output logic      pause_n,   // pause
  input  wire logic dout_o,    // data from device
  input  wire logic dout_oe_n  // device drives when low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 40;
  logic       cpol;
  logic [7:0] got;
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    din = 1'b0;
    pause_n = 1'b1;
    cpol = 1'b0;
    got = 8'h00;
  end
  task automatic sel(input logic mode);
    cpol = mode;
    sck = mode;
    #HALF;
    sel_n = 1'b0;
    #(2 * HALF);
  endtask : sel
  task automatic desel();
    #HALF;
    sel_n = 1'b1;
    din = ~din;
    #HALF;
  endtask : desel
  // released output reads as the inverse of the last bit
  task automatic bits(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      din = v[7 - i];
      #HALF;
      sck = 1'b1;
      #HALF;
      got = {got[6:0], dout_oe_n ? ~got[0] : dout_o};
    end
    sck = cpol;
  endtask : bits
  task automatic hold(input int n);
    pause_n = 1'b0;
    for (int i = 0; i < 2 * n; i++) begin
      #HALF;
      sck = ~sck;
      din = ~din;
    end
    #HALF;
    pause_n = 1'b1;
    #HALF;
  endtask : hold
endmodule : spi_master_model

/* tb/tb.sv */
// self-checking bench for the serial flash link front end
// assumes the master model drives the link pins and the bench plays the core
module tb;
  import flash_front_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, sck, sel_n, din, pause_n, dout_o, dout_oe_n, rx_valid, rx_first, tx_need;
  logic frame_whole, standby, active, rst = 1'b1, rx_ready = 1'b0, tx_load = 1'b0, frame_end;
  int fe_cnt = 0;
  int tn_cnt = 0;
  logic busy = 1'b0, stall = 1'b0, wprot_n = 1'b1, lock_en = 1'b0, prot_wr = 1'b0;
  logic [7:0] rx_data, b, pidx, pofs;
  logic [2:0] prot_size, r, prot_req = 3'h0, pe = PROTECT_RESET;
  logic [ADDR_BITS-1:0] page_next, a, addr_in = '0;
  logic [4:0] sect;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'h4b48;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  flash_spi_front dut (.CLK_SYS(clk_sys), .RST(rst), .SCK(sck), .SEL_N(sel_n), .DIN(din),
    .PAUSE_N(pause_n), .WPROT_N(wprot_n), .DOUT_O(dout_o), .DOUT_OE_N(dout_oe_n),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_FIRST(rx_first),
    .TX_DATA(8'hc8), .TX_LOAD(tx_load), .TX_NEED(tx_need), .FRAME_END(frame_end),
    .FRAME_WHOLE(frame_whole), .BUSY(busy), .STANDBY(standby), .ACTIVE(active),
    .PROT_REQ(prot_req), .PROT_WR(prot_wr), .PROT_LOCK_EN(lock_en), .PROT_SIZE(prot_size),
    .ADDR_IN(addr_in), .SECTOR_IDX(sect), .PAGE_IDX(pidx), .PAGE_OFS(pofs),
    .PAGE_NEXT(page_next));
  spi_master_model m (.sck(sck), .sel_n(sel_n), .din(din), .pause_n(pause_n),
    .dout_o(dout_o), .dout_oe_n(dout_oe_n));
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // plays the core: random rx stalls, reloads the reply byte, checks rx bytes
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rx_ready <= !stall && (xorshift() & 32'h3) != 0;
    tx_load <= tx_need | sel_n;
    if (frame_end) fe_cnt <= fe_cnt + 1;
    if (tx_need) tn_cnt <= tn_cnt + 1;
    if (rx_valid && rx_ready) begin
      if (exp_q.size() == 0) check("rx_extra", 1, 0);
      else check("rx_byte", {rx_first, rx_data}, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge clk_sys);
    check("rx_left", exp_q.size(), 0);
  endtask : drain
  task automatic frame(input logic mode, input int n);
    m.sel(mode);
    check("active", active, 1'b1);
    for (int i = 0; i < n; i++) begin
      b = 8'(xorshift());
      exp_q.push_back({i == 0, b});
      m.bits(b, 8);
      if (i > 0) check("dout_byte", m.got, 8'hc8);
    end
    m.desel();
    repeat (4) @(posedge clk_sys);
    check("oe_n", dout_oe_n, 1'b1);
    check("standby", standby, !busy);
    check("whole", frame_whole, 1'b1);
  endtask : frame
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    m.bits(8'h5a, 8);
    check("unarmed", {active, standby, dout_oe_n}, 3'b001);
    $display("test unarmed done");
    for (int k = 0; k < 4; k++) frame(k[0], 2 + k);
    drain();
    $display("test frames done");
    m.sel(1'b0);
    exp_q.push_back({1'b1, 8'h96});
    m.bits(8'h96, 3);
    m.hold(5);
    m.bits(8'hb0, 5);
    m.desel();
    drain();
    m.sel(1'b1);
    m.bits(8'h3c, 5);
    m.desel();
    repeat (4) @(posedge clk_sys);
    check("part_whole", frame_whole, 1'b0);
    $display("test pause and partial done");
    busy <= 1'b1;
    frame(1'b0, 1);
    busy <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check("standby_late", standby, 1'b1);
    stall <= 1'b1;
    frame(1'b1, 2);
    check("rx_held", rx_valid, 1'b1);
    stall <= 1'b0;
    drain();
    $display("test busy and buffer done");
    for (int k = 0; k < 8; k++) begin
      r = 3'(xorshift());
      wprot_n <= k[0];
      lock_en <= k[1];
      prot_req <= r;
      repeat (4) @(posedge clk_sys);
      prot_wr <= 1'b1;
      @(posedge clk_sys);
      prot_wr <= 1'b0;
      if (!(k[1] && !k[0])) pe = r;
      repeat (2) @(posedge clk_sys);
      check("prot_size", prot_size, pe);
    end
    for (int k = 0; k < 8; k++) begin
      a = (k == 0) ? '1 : (k == 1) ? 21'h0000ff : 21'(xorshift());
      addr_in <= a;
      repeat (2) @(posedge clk_sys);
      check("addr_split", {sect, pidx, pofs}, a);
      check("page_next", page_next, {a[20:8], a[7:0] + 8'h1});
    end
    $display("test protect and geometry done");
    check("frame_ends", fe_cnt, 7);
    check("byte_bounds", tn_cnt, 18);
    tally_and_finish();
  end
endmodule : tb
